// ==== rtl/status_pkg.sv ====
// Constants, register map and command codes of the status summary block
// Behaviour
// - Status byte is built from four register-set summaries and two queue summaries.
// - Any status byte bit enabled by service enable sets the master summary bit.
// - Condition registers are read-only and follow live conditions without latching.
// - An event on B0 to B14 sets its event bit, held until the event register is cleared.
// - Set summary is high when any event bit and its enable bit are both high.
// - Each queue raises its status byte bit while it holds an entry.
// - Reset clears every register and empties both queues.
// - Writing zero to an enable register clears all its bits.
// - System preset and reset command leave status registers and queues unchanged.
// - Clear-status clears all four event registers and empties the error queue.
// - Status preset clears operation, measurement and questionable enable registers.
// - Standard enable register is changed only by its own write.
// - Status preset leaves the error queue alone.
// - Queue clear and system clear both empty the error queue.
// - Only enable registers and the command register are writable; all others are read-only.
// - Written value maps bit n to weight two to the n.
// - Status registers are sixteen bits wide, bits B0 to B15.
// - A register read returns the binary contents, the sum of bit weights.
// - Bit 6 is request-service in the poll byte, master summary in status read.
// - Summaries sit at B0,B2,B3,B4,B5,B7; B1 is unused.
// - Status byte summary bits follow their sources directly, without latching.
// - Serial poll clears request-service only; master summary follows enabled bits.
package status_pkg;

    localparam int REG_W  = 16;
    localparam int ADDR_W = 5;
    localparam int NSETS  = 4;

    // Register sets, index into the per-set arrays
    localparam int SET_STD  = 0;
    localparam int SET_OPER = 1;
    localparam int SET_MEAS = 2;
    localparam int SET_QUES = 3;

    // Per-set offsets: base = set*4, then condition, event, enable
    localparam logic [ADDR_W-1:0] OFS_COND = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_EVT  = 5'h01;
    localparam logic [ADDR_W-1:0] OFS_ENA  = 5'h02;
    localparam int                SET_STRIDE = 4;

    localparam logic [ADDR_W-1:0] ADDR_STB     = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_SRE     = 5'h11;
    localparam logic [ADDR_W-1:0] ADDR_SPOLL   = 5'h12;
    localparam logic [ADDR_W-1:0] ADDR_CMD     = 5'h13;
    localparam logic [ADDR_W-1:0] ADDR_QCOUNT  = 5'h14;

    // Command register bits (write one to act)
    localparam int CMD_CLS        = 0;
    localparam int CMD_STAT_PRE   = 1;
    localparam int CMD_QUEUE_CLR  = 2;
    localparam int CMD_SYS_CLR    = 3;
    localparam int CMD_SYS_PRE    = 4;
    localparam int CMD_RST        = 5;

    // Status byte bit positions
    localparam int STB_MEAS   = 0;
    localparam int STB_UNUSED = 1;
    localparam int STB_ERR_AVL = 2;
    localparam int STB_QUES   = 3;
    localparam int STB_MAV    = 4;
    localparam int STB_STD    = 5;
    localparam int STB_MSS    = 6;
    localparam int STB_OPER   = 7;

    localparam int TOP_BIT = 15;
    localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
    localparam logic [REG_W-1:0] LIVE_MASK = 16'h7fff;
    localparam logic [7:0]       SRE_MASK  = 8'hbd;

endpackage : status_pkg

// ==== rtl/status_event_summary.sv ====
// Status register sets, queue summaries, status byte and service request
module status_event_summary #(
    parameter int QDEPTH = 16
) (
    input  wire logic                          clk,
    input  wire logic                          nrst,
    input  wire logic [status_pkg::ADDR_W-1:0] addr,
    input  wire logic [status_pkg::REG_W-1:0]  wdata,
    input  wire logic                          wr,
    input  wire logic                          rd,
    output logic      [status_pkg::REG_W-1:0]  rdata,
    input  wire logic [status_pkg::REG_W-1:0]  cond_std,
    input  wire logic [status_pkg::REG_W-1:0]  cond_oper,
    input  wire logic [status_pkg::REG_W-1:0]  cond_meas,
    input  wire logic [status_pkg::REG_W-1:0]  cond_ques,
    input  wire logic [status_pkg::REG_W-1:0]  pulse_std,
    input  wire logic [status_pkg::REG_W-1:0]  pulse_oper,
    input  wire logic [status_pkg::REG_W-1:0]  pulse_meas,
    input  wire logic [status_pkg::REG_W-1:0]  pulse_ques,
    input  wire logic                          out_push,
    input  wire logic                          out_pop,
    input  wire logic                          err_push,
    input  wire logic                          err_pop,
    output logic                               srq,
    output logic      [7:0]                    status_byte
);
    import status_pkg::*;

    localparam int CW = $clog2(QDEPTH + 1);

    initial begin
        if (QDEPTH < 1) begin
            $error("QDEPTH must be at least 1");
        end
    end

    logic [REG_W-1:0] cond_raw [NSETS];
    logic [REG_W-1:0] pulse_raw [NSETS];
    logic [REG_W-1:0] cond_s1 [NSETS];
    logic [REG_W-1:0] cond_s2 [NSETS];
    logic [REG_W-1:0] cond_d [NSETS];
    logic [REG_W-1:0] pulse_s1 [NSETS];
    logic [REG_W-1:0] pulse_s2 [NSETS];
    logic [REG_W-1:0] evt [NSETS];
    logic [REG_W-1:0] next_evt [NSETS];
    logic [REG_W-1:0] ena [NSETS];
    logic [REG_W-1:0] next_ena [NSETS];
    logic [NSETS-1:0] set_sum;
    logic [7:0]       sre;
    logic [7:0]       next_sre;
    logic             rqs;
    logic             next_rqs;
    logic             mss_d;
    logic [4:0]       sync_s1;
    logic [4:0]       sync_s2;
    logic [4:0]       sync_d;
    logic [CW-1:0]    out_cnt;
    logic [CW-1:0]    next_out_cnt;
    logic [CW-1:0]    err_cnt;
    logic [CW-1:0]    next_err_cnt;
    logic [REG_W-1:0] next_rdata;
    logic [7:0]       stb;
    logic             mss;
    logic             cmd_wr;
    logic             push_o;
    logic             pop_o;
    logic             push_e;
    logic             pop_e;

    assign cond_raw[SET_STD]   = cond_std;
    assign cond_raw[SET_OPER]  = cond_oper;
    assign cond_raw[SET_MEAS]  = cond_meas;
    assign cond_raw[SET_QUES]  = cond_ques;
    assign pulse_raw[SET_STD]  = pulse_std;
    assign pulse_raw[SET_OPER] = pulse_oper;
    assign pulse_raw[SET_MEAS] = pulse_meas;
    assign pulse_raw[SET_QUES] = pulse_ques;

    // Register address of a field in set s
    function automatic logic [ADDR_W-1:0] set_addr(input int s, input logic [ADDR_W-1:0] ofs);
        set_addr = ADDR_W'(s * SET_STRIDE) + ofs;
    endfunction

    assign cmd_wr = wr && (addr == ADDR_CMD);

    // Sources come from other logic blocks that may be asynchronous, so all are synchronised
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sync_s1 <= '0;
            sync_s2 <= '0;
            sync_d  <= '0;
            for (int s = 0; s < NSETS; s++) begin
                cond_s1[s]  <= REG_RESET;
                cond_s2[s]  <= REG_RESET;
                cond_d[s]   <= REG_RESET;
                pulse_s1[s] <= REG_RESET;
                pulse_s2[s] <= REG_RESET;
            end
        end else begin
            sync_s1 <= {out_push, out_pop, err_push, err_pop, 1'b0};
            sync_s2 <= sync_s1;
            sync_d  <= sync_s2;
            for (int s = 0; s < NSETS; s++) begin
                cond_s1[s]  <= cond_raw[s];
                cond_s2[s]  <= cond_s1[s];
                cond_d[s]   <= cond_s2[s];
                pulse_s1[s] <= pulse_raw[s];
                pulse_s2[s] <= pulse_s1[s];
            end
        end
    end

    // Queue strobes are edge detected after synchronising
    assign push_o = sync_s2[4] && !sync_d[4];
    assign pop_o  = sync_s2[3] && !sync_d[3];
    assign push_e = sync_s2[2] && !sync_d[2];
    assign pop_e  = sync_s2[1] && !sync_d[1];

    generate
        for (genvar g = 0; g < NSETS; g++) begin : g_set
            always_comb begin
                next_evt[g] = evt[g];
                next_ena[g] = ena[g];
                if (cmd_wr && wdata[CMD_CLS]) begin
                    next_evt[g] = REG_RESET;
                end
                // events latch; rising edge or pulse, set wins over clear
                next_evt[g] = (next_evt[g] | (cond_s2[g] & ~cond_d[g]) | pulse_s2[g]) & LIVE_MASK;
                // status preset clears enables; except standard set
                if (cmd_wr && wdata[CMD_STAT_PRE] && g != SET_STD) begin
                    next_ena[g] = REG_RESET;
                end
                // only enables writable; binary write, zero clears
                if (wr && addr == set_addr(g, OFS_ENA)) begin
                    next_ena[g] = wdata & LIVE_MASK;
                end
            end

            always_ff @(posedge clk) begin
                if (!nrst) begin
                    evt[g] <= REG_RESET;
                    ena[g] <= REG_RESET;
                end else begin
                    evt[g] <= next_evt[g];
                    ena[g] <= next_ena[g];
                end
            end

            assign set_sum[g] = |(evt[g] & ena[g] & LIVE_MASK);
        end
    endgenerate

    // Queue occupancy counters; system preset and reset commands are ignored here
    always_comb begin
        next_out_cnt = out_cnt;
        next_err_cnt = err_cnt;
        if (push_o && !pop_o && out_cnt != CW'(QDEPTH)) begin
            next_out_cnt = out_cnt + CW'(1);
        end else if (pop_o && !push_o && out_cnt != '0) begin
            next_out_cnt = out_cnt - CW'(1);
        end
        if (push_e && !pop_e && err_cnt != CW'(QDEPTH)) begin
            next_err_cnt = err_cnt + CW'(1);
        end else if (pop_e && !push_e && err_cnt != '0) begin
            next_err_cnt = err_cnt - CW'(1);
        end
        // error queue clears; status preset does not
        if (cmd_wr && (wdata[CMD_CLS] || wdata[CMD_QUEUE_CLR] || wdata[CMD_SYS_CLR])) begin
            next_err_cnt = '0;
        end
    end

    always_comb begin
        stb             = '0;
        stb[STB_MEAS]   = set_sum[SET_MEAS];
        stb[STB_ERR_AVL] = err_cnt != '0;
        stb[STB_QUES]   = set_sum[SET_QUES];
        stb[STB_MAV]    = out_cnt != '0;
        stb[STB_STD]    = set_sum[SET_STD];
        stb[STB_OPER]   = set_sum[SET_OPER];
        mss             = |(stb & sre & SRE_MASK);
        stb[STB_MSS]    = mss;
    end

    always_comb begin
        next_sre = sre;
        next_rqs = rqs;
        if (wr && addr == ADDR_SRE) begin
            next_sre = wdata[7:0] & SRE_MASK;
        end
        // poll clears request-service; a new rise of master summary sets it again
        if (rd && addr == ADDR_SPOLL) begin
            next_rqs = 1'b0;
        end
        if (mss && !mss_d) begin
            next_rqs = 1'b1;
        end
    end

    always_comb begin
        next_rdata = '0;
        if (rd) begin
            for (int s = 0; s < NSETS; s++) begin
                if (addr == set_addr(s, OFS_COND)) begin
                    next_rdata = cond_s2[s];
                end
                if (addr == set_addr(s, OFS_EVT)) begin
                    next_rdata = evt[s];
                end
                if (addr == set_addr(s, OFS_ENA)) begin
                    next_rdata = ena[s];
                end
            end
            if (addr == ADDR_STB) begin
                next_rdata = {8'h00, stb};
            end
            if (addr == ADDR_SRE) begin
                next_rdata = {8'h00, sre};
            end
            if (addr == ADDR_SPOLL) begin
                next_rdata = {8'h00, stb[7], rqs, stb[5:0]};
            end
            if (addr == ADDR_QCOUNT) begin
                next_rdata = {8'(err_cnt), 8'(out_cnt)};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sre     <= '0;
            rqs     <= 1'b0;
            mss_d   <= 1'b0;
            out_cnt <= '0;
            err_cnt <= '0;
            rdata   <= '0;
        end else begin
            sre     <= next_sre;
            rqs     <= next_rqs;
            mss_d   <= mss;
            out_cnt <= next_out_cnt;
            err_cnt <= next_err_cnt;
            rdata   <= next_rdata;
        end
    end

    assign srq         = rqs;
    assign status_byte = stb;

endmodule // status_event_summary

// ==== testbench/status_event_summary_asserts.sv ====
// Port-level assertions of the status summary block
module status_event_summary_asserts
    import status_pkg::*;
#(
    parameter int QDEPTH = 16
) (
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [REG_W-1:0]  wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [REG_W-1:0]  rdata,
    input wire logic              out_push,
    input wire logic              err_push,
    input wire logic              err_pop,
    input wire logic              srq,
    input wire logic [7:0]        status_byte
);
    localparam int ERR_BIT = 2;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // Shadow of the service enable, so the master summary can be checked from the ports
    logic [7:0] sre;
    logic [7:0] next_sre;
    logic       cmd_wr;
    always_comb begin
        next_sre = sre;
        if (wr && addr == ADDR_SRE) begin
            next_sre = wdata[7:0] & SRE_MASK;
        end
    end
    always_ff @(posedge clk) begin
        sre <= nrst ? next_sre : 8'h00;
    end
    assign cmd_wr = wr && addr == ADDR_CMD;

    // Error queue strobes stay low long enough that no entry is still in the synchroniser
    sequence err_quiet;
        (!err_push && !err_pop) [*4];
    endsequence
    sequence mss_steady;
        status_byte[STB_MSS] [*3];
    endsequence

    a_read_idle_zero: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data not zero outside an answer");
    a_mss_from_sre: assert property (status_byte[STB_MSS] == |(status_byte & sre))
        else $error("master summary does not match enabled bits");
    a_unused_bit_low: assert property (status_byte[STB_UNUSED] == 1'b0)
        else $error("unused status bit set");
    a_srq_on_rise: assert property ($rose(status_byte[STB_MSS]) |-> ##[0:2] srq)
        else $error("service request missing after summary rise");
    a_poll_clears_rqs: assert property (mss_steady ##0 (rd && addr == ADDR_SPOLL) |=> !srq)
        else $error("poll did not clear request flag");
    a_err_sets_bit: assert property ($rose(err_push) |-> ##[1:4] status_byte[ERR_BIT])
        else $error("error entry not summarised");
    a_out_sets_mav: assert property ($rose(out_push) |-> ##[1:4] status_byte[STB_MAV])
        else $error("output entry not summarised");
    a_cls_empties_err: assert property (err_quiet ##0 (cmd_wr && wdata[CMD_CLS]) |=>
        !status_byte[ERR_BIT])
        else $error("clear status left error entries");
    a_qclr_empties_err: assert property (err_quiet ##0
        (cmd_wr && (wdata[CMD_QUEUE_CLR] || wdata[CMD_SYS_CLR])) |=> !status_byte[ERR_BIT])
        else $error("queue clear left error entries");
    a_spre_keeps_err: assert property (err_quiet ##0
        (cmd_wr && wdata == 16'h0002 && status_byte[ERR_BIT]) |=> status_byte[ERR_BIT])
        else $error("status preset emptied error queue");
endmodule // status_event_summary_asserts

bind status_event_summary status_event_summary_asserts #(.QDEPTH(QDEPTH)) u_asserts (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .out_push(out_push), .err_push(err_push), .err_pop(err_pop), .srq(srq),
    .status_byte(status_byte)
);

// ==== testbench/host_model.sv ====
// Host controller model speaking the register port
module host_model
    import status_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [REG_W-1:0]  rdata,
    output logic      [ADDR_W-1:0] addr,
    output logic      [REG_W-1:0]  wdata,
    output logic                   wr,
    output logic                   rd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
    end
    // value sent as plain binary weights
    // Idle bus shows inverted values so a stale address is never read as valid
    task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask
endmodule // host_model

// ==== testbench/status_event_summary_tb.sv ====
// Self-checking testbench of the status summary block
module status_event_summary_tb
    import status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SUMB [NSETS] = '{STB_STD, STB_OPER, STB_MEAS, STB_QUES};
    logic              clk, nrst, wr, rd, srq;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0]  wdata, rdata;
    logic [REG_W-1:0]  cond [NSETS];
    logic [REG_W-1:0]  pulse [NSETS];
    logic [3:0]        qs;
    logic [7:0]        status_byte;
    int                n_mismatch, tests_run;

    host_model u_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
    status_event_summary #(.QDEPTH(16)) u_dut (
        .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .cond_std(cond[0]), .cond_oper(cond[1]), .cond_meas(cond[2]), .cond_ques(cond[3]),
        .pulse_std(pulse[0]), .pulse_oper(pulse[1]), .pulse_meas(pulse[2]),
        .pulse_ques(pulse[3]), .out_push(qs[0]), .out_pop(qs[1]), .err_push(qs[2]),
        .err_pop(qs[3]), .srq(srq), .status_byte(status_byte)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [ADDR_W-1:0] ra(input int s, input logic [ADDR_W-1:0] o);
        return ADDR_W'(s * SET_STRIDE) + o;
    endfunction
    task automatic chk(input logic [REG_W-1:0] got_v, input logic [REG_W-1:0] exp_v);
        tests_run++;
        if (got_v !== exp_v) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] exp_v);
        logic [REG_W-1:0] d;
        u_host.read_reg(a, d);
        chk(d, exp_v);
    endtask
    // Queue strobe, then wait out the input synchroniser
    task automatic qstrobe(input logic [3:0] m);
        @(posedge clk);
        qs <= m;
        @(posedge clk);
        qs <= 4'h0;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic chk_sb(input logic [7:0] e);
        chk({8'h00, status_byte}, {8'h00, e});
    endtask

    task automatic t_reset_values();
        for (int a = 0; a < 32; a++) begin
            rchk(ADDR_W'(a), REG_RESET);
        end
        chk_sb(8'h00);
    endtask
    task automatic t_enables();
        for (int s = 0; s < NSETS; s++) begin
            u_host.write_reg(ra(s, OFS_ENA), 16'hffff);
            rchk(ra(s, OFS_ENA), LIVE_MASK);
            u_host.write_reg(ra(s, OFS_ENA), 16'h0000);
            rchk(ra(s, OFS_ENA), 16'h0000);
            u_host.write_reg(ra(s, OFS_COND), 16'hffff);
            u_host.write_reg(ra(s, OFS_EVT), 16'hffff);
            rchk(ra(s, OFS_COND), 16'h0000);
            rchk(ra(s, OFS_EVT), 16'h0000);
        end
        u_host.write_reg(ADDR_SRE, 16'h00ff);
        rchk(ADDR_SRE, {8'h00, SRE_MASK});
        u_host.write_reg(ADDR_SRE, 16'h0000);
        u_host.write_reg(ADDR_STB, 16'hffff);
        rchk(ADDR_STB, 16'h0000);
    endtask
    task automatic t_events();
        logic [REG_W-1:0] b;
        for (int s = 0; s < NSETS; s++) begin
            b = 16'h0008 << s;
            @(posedge clk);
            cond[s] <= b;
            repeat (4) @(posedge clk);
            rchk(ra(s, OFS_COND), b);
            @(posedge clk);
            cond[s] <= 16'h0000;
            pulse[s] <= 16'h8001;
            @(posedge clk);
            pulse[s] <= 16'h0000;
            repeat (4) @(posedge clk);
            rchk(ra(s, OFS_COND), 16'h0000);
            rchk(ra(s, OFS_EVT), b | 16'h0001);
            chk({15'h0, status_byte[SUMB[s]]}, 16'h0000);
            u_host.write_reg(ra(s, OFS_ENA), b);
            #1;
            chk({15'h0, status_byte[SUMB[s]]}, 16'h0001);
            // Top bit enable write is masked off, so the summary drops
            u_host.write_reg(ra(s, OFS_ENA), 16'h8000);
            #1;
            chk({15'h0, status_byte[SUMB[s]]}, 16'h0000);
            u_host.write_reg(ra(s, OFS_ENA), b);
        end
    endtask
    task automatic t_commands();
        qstrobe(4'b0101);
        chk_sb(8'hbd);
        u_host.write_reg(ADDR_CMD, 16'h0030);
        #1;
        chk_sb(8'hbd);
        rchk(ra(SET_OPER, OFS_ENA), 16'h0010);
        u_host.write_reg(ADDR_CMD, 16'h0002);
        for (int s = 1; s < NSETS; s++) begin
            rchk(ra(s, OFS_ENA), 16'h0000);
        end
        rchk(ra(SET_STD, OFS_ENA), 16'h0008);
        chk_sb(8'h34);
        u_host.write_reg(ADDR_CMD, 16'h0001);
        for (int s = 0; s < NSETS; s++) begin
            rchk(ra(s, OFS_EVT), 16'h0000);
        end
        rchk(ra(SET_STD, OFS_ENA), 16'h0008);
        chk_sb(8'h10);
        qstrobe(4'b0010);
        chk_sb(8'h00);
        for (int c = 2; c < 4; c++) begin
            qstrobe(4'b0100);
            u_host.write_reg(ADDR_CMD, REG_W'(1) << c);
            #1;
            chk_sb(8'h00);
        end
    endtask
    task automatic t_poll();
        qstrobe(4'b0100);
        u_host.write_reg(ADDR_SRE, 16'h0004);
        repeat (3) @(posedge clk);
        #1;
        chk({15'h0, srq}, 16'h0001);
        rchk(ADDR_SPOLL, 16'h0044);
        chk({15'h0, srq}, 16'h0000);
        rchk(ADDR_STB, 16'h0044);
        rchk(ADDR_SPOLL, 16'h0004);
        qstrobe(4'b1000);
        chk_sb(8'h00);
    endtask

    task automatic summarize();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        nrst = 1'b0;
        qs = 4'h0;
        cond = '{default: '0};
        pulse = '{default: '0};
        n_mismatch = 0;
        tests_run = 0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_reset_values();
        t_enables();
        t_events();
        t_commands();
        t_poll();
        summarize();
    end
    // Whole sequence needs well under two thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        $display("CHECK FAILED at %0t: timeout", $time);
        summarize();
    end
endmodule // status_event_summary_tb
